// ==== inc/rrb_pkg.sv ====
// Operation
// RL1 - Word count field is zero-based dword count
// RL2 - Short request returns only leading words
// RL3 - Long request returns whole structure, no extra
// RL4 - Format bit zero selects extended structure
// RL5 - Bytes 0-3 carry wrapping 32-bit generation
// RL6 - Successful register completion bumps generation
// RL7 - Successful release-clear completion bumps generation
// RL8 - Successful preempt acquire completion bumps generation
// RL9 - Byte 4 reports reservation kind
// RL10 - Bytes 5-6 report registrant controller count
// RL11 - Byte 9 reports persistence, others reserved
// RL12 - Standard entries are 24 bytes from 24
// RL13 - Extended header 64 bytes, 64-byte entries
// RL14 - Entry holds id, hold bit, host, key
// RL15 - Post completion status after the transfer
// RL16 - One shared counter, step one, rolls over
package rrb_pkg;
	// Register map, byte addresses on the plain port
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_WCNT  = 8'h04;
	localparam logic [7:0] ADDR_FMT   = 8'h08;
	localparam logic [7:0] ADDR_NSST  = 8'h0C;
	localparam logic [7:0] ADDR_RCNT  = 8'h10;
	localparam logic [7:0] ADDR_STAT  = 8'h14;
	localparam logic [7:0] ADDR_GEN   = 8'h18;
	localparam int         ENT_SEL_BIT = 7;
	// Entry field selects within a 32-byte entry window
	localparam logic [2:0] FLD_ID     = 3'h0;
	localparam logic [2:0] FLD_HID_LO = 3'h1;
	localparam logic [2:0] FLD_HID_HI = 3'h2;
	localparam logic [2:0] FLD_KEY_LO = 3'h3;
	localparam logic [2:0] FLD_KEY_HI = 3'h4;
	// Field positions
	localparam int CTRL_START_BIT = 0;
	localparam int FMT_EXT_BIT    = 0;
	localparam int NSST_PTPL_BIT  = 8;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_DONE_BIT  = 1;
	localparam int KIND_LSB       = 0;
	localparam int COUNT_LSB      = 8;
	localparam int PTPL_BIT       = 8;
	localparam int HOLD_BIT       = 16;
	// Table size
	localparam int         ENTRY_MAX = 4;
	localparam logic [2:0] COUNT_MAX = 3'h4;
	// Structure geometry in dwords
	localparam logic [4:0] STD_HDR_WORDS = 5'h06;
	localparam logic [4:0] STD_ENT_WORDS = 5'h06;
	localparam logic [4:0] EXT_HDR_WORDS = 5'h10;
	localparam logic [4:0] EXT_ENT_WORDS = 5'h10;
	localparam logic [4:0] HDR_W_GEN  = 5'h00;
	localparam logic [4:0] HDR_W_KIND = 5'h01;
	localparam logic [4:0] HDR_W_PTPL = 5'h02;
	localparam logic [4:0] ENT_W_ID   = 5'h00;
	localparam logic [4:0] STD_W_HID  = 5'h02;
	localparam logic [4:0] STD_W_KEY  = 5'h04;
	localparam logic [4:0] EXT_W_KEY  = 5'h02;
	localparam logic [4:0] EXT_W_HID  = 5'h04;
	// Action codes that advance the generation, and the success status
	localparam logic [2:0] REL_CLEAR         = 3'h1;
	localparam logic [2:0] ACQ_PREEMPT       = 3'h1;
	localparam logic [2:0] ACQ_PREEMPT_ABORT = 3'h2;
	localparam logic [15:0] STATUS_SUCCESS   = 16'h0000;
	typedef enum logic [1:0] {
		RRB_IDLE = 2'b00,
		RRB_SEND = 2'b01,
		RRB_CPL  = 2'b10
	} rrb_state_t;
endpackage

// ==== verilog/rrb_gen_counter.sv ====
`timescale 1ns/10ps
module rrb_gen_counter
	import rrb_pkg::*;
(
	input  wire logic        i_clock,        // Core clock
	input  wire logic        i_nrst,         // Async reset, active low
	input  wire logic        i_register_ok,  // Register command succeeded
	input  wire logic        i_release_ok,   // Release command succeeded
	input  wire logic [2:0]  i_release_action_code, // Its action code
	input  wire logic        i_acquire_ok,   // Acquire command succeeded
	input  wire logic [2:0]  i_acquire_action_code, // Its action code
	output logic      [31:0] o_generation_counter   // Shared generation
);
	logic [31:0] gen_reg;
	logic [31:0] gen_next;
	logic [1:0]  bumps;

	// Same-cycle completions each count, so none is lost
	always_comb begin
		bumps = 2'(i_register_ok);                                          // RL6
		bumps = bumps + 2'(i_release_ok && i_release_action_code == REL_CLEAR); // RL7
		bumps = bumps + 2'(i_acquire_ok && (i_acquire_action_code == ACQ_PREEMPT ||
			i_acquire_action_code == ACQ_PREEMPT_ABORT));                   // RL8
		gen_next = gen_reg + 32'(bumps);                                    // RL16
	end

	// Plain modular add: wraps instead of saturating
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			gen_reg <= 32'h00000000;
		end else begin
			gen_reg <= gen_next;                                            // RL5
		end
	end

	assign o_generation_counter = gen_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	property p_gen_reg_step;
		i_register_ok && !i_release_ok && !i_acquire_ok |=> gen_reg == $past(gen_reg) + 32'h00000001;
	endproperty
	a_gen_reg_step: assert property (p_gen_reg_step) else $error("generation missed a register"); // RL6

	property p_gen_release;
		!i_register_ok && !i_acquire_ok && i_release_ok |=>
			gen_reg == $past(gen_reg) + 32'($past(i_release_action_code) == REL_CLEAR);
	endproperty
	a_gen_release: assert property (p_gen_release) else $error("generation wrong on release"); // RL7

	property p_gen_idle;
		!i_register_ok && !i_release_ok && !i_acquire_ok |=> $stable(gen_reg);
	endproperty
	a_gen_idle: assert property (p_gen_idle) else $error("generation moved without event"); // RL16
endmodule

// ==== verilog/rrb_len_clamp.sv ====
`timescale 1ns/10ps
module rrb_len_clamp
	import rrb_pkg::*;
(
	input  wire logic        i_ext,      // Extended format chosen
	input  wire logic [2:0]  i_count,    // Registrant entries
	input  wire logic [31:0] i_wcnt,     // Zero-based requested words
	output logic      [31:0] o_words     // Words to send
);
	logic [7:0] total;

	// Structure size, then the smaller of request and size
	always_comb begin
		if (i_ext) begin
			total = 8'(EXT_HDR_WORDS) + 8'(i_count) * 8'(EXT_ENT_WORDS); // RL13
		end else begin
			total = 8'(STD_HDR_WORDS) + 8'(i_count) * 8'(STD_ENT_WORDS); // RL12
		end
		// Compare before adding one so an all-ones request cannot wrap
		if (i_wcnt < 32'(total)) begin
			o_words = i_wcnt + 32'h00000001;                              // RL1 RL2
		end else begin
			o_words = 32'(total);                                         // RL3
		end
	end
endmodule

// ==== verilog/rrb_report_builder.sv ====
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
module rrb_report_builder
	import rrb_pkg::*;
(
	input  wire logic        i_clock,         // 125 MHz core clock
	input  wire logic        i_nrst,          // Async reset, active low
	input  wire logic [7:0]  i_addr,          // Register byte address
	input  wire logic [31:0] i_wdata,         // Register write data
	input  wire logic        i_wr,            // Write strobe
	input  wire logic        i_rd,            // Read strobe
	output logic      [31:0] o_rdata,         // Read data, cycle after strobe
	input  wire logic        i_register_ok,   // Register command succeeded
	input  wire logic        i_release_ok,    // Release command succeeded
	input  wire logic [2:0]  i_release_action_code, // Release action
	input  wire logic        i_acquire_ok,    // Acquire command succeeded
	input  wire logic [2:0]  i_acquire_action_code, // Acquire action
	output logic             o_data_valid,    // Report word valid
	output logic      [31:0] o_data_word,     // Report word
	output logic             o_cqe_valid,     // Completion entry pulse
	output logic      [15:0] o_cqe_status,    // Completion status
	output logic             o_busy           // Command in progress
);
	rrb_state_t  state_reg, state_next;
	logic [31:0] wcnt_reg, wcnt_next;
	logic        fmt_reg, fmt_next;
	logic [7:0]  kind_reg, kind_next;
	logic        ptpl_reg, ptpl_next;
	logic [2:0]  rcnt_reg, rcnt_next;
	logic        done_reg, done_next;
	logic        ext_reg, ext_next;
	logic [2:0]  cnt_snap_reg, cnt_snap_next;
	logic [7:0]  kind_snap_reg, kind_snap_next;
	logic        ptpl_snap_reg, ptpl_snap_next;
	logic [31:0] gen_snap_reg, gen_snap_next;
	logic [31:0] words_reg, words_next;
	logic [31:0] sent_reg, sent_next;
	logic [4:0]  ofs_reg, ofs_next;
	logic [2:0]  ent_reg, ent_next;
	logic        in_hdr_reg, in_hdr_next;
	logic        dv_next;
	logic [31:0] dw_next;
	logic        cqe_next;
	logic [31:0] rdata_next;
	logic [31:0] gen;
	logic [31:0] clamp_words;
	logic        start;
	logic        ent_wr;
	logic [1:0]  ent_idx;
	logic [2:0]  ent_fld;
	logic [4:0]  rec_last;
	logic [1:0]  cur_ent;
	logic [15:0] id_mem   [ENTRY_MAX];
	logic        hold_mem [ENTRY_MAX];
	logic [63:0] hid_mem  [ENTRY_MAX];
	logic [63:0] key_mem  [ENTRY_MAX];

	////////////////////////////////////////////////////////////////////////////////
	// Shared generation counter and report length
	rrb_gen_counter u_gen (
		.i_clock               (i_clock),
		.i_nrst                (i_nrst),
		.i_register_ok         (i_register_ok),
		.i_release_ok          (i_release_ok),
		.i_release_action_code (i_release_action_code),
		.i_acquire_ok          (i_acquire_ok),
		.i_acquire_action_code (i_acquire_action_code),
		.o_generation_counter  (gen)
	);

	rrb_len_clamp u_len (
		.i_ext   (fmt_reg),
		.i_count (rcnt_reg),
		.i_wcnt  (wcnt_reg),
		.o_words (clamp_words)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register decode
	assign start   = i_wr && i_addr == ADDR_CTRL && i_wdata[CTRL_START_BIT];
	assign ent_wr  = i_wr && i_addr[ENT_SEL_BIT];
	assign ent_idx = i_addr[6:5];
	assign ent_fld = i_addr[4:2];
	assign cur_ent = ent_reg[1:0];

	// Software configuration and readback
	always_comb begin
		wcnt_next  = wcnt_reg;
		fmt_next   = fmt_reg;
		kind_next  = kind_reg;
		ptpl_next  = ptpl_reg;
		rcnt_next  = rcnt_reg;
		rdata_next = 32'h00000000;
		if (i_wr && i_addr == ADDR_WCNT) begin
			wcnt_next = i_wdata;                               // RL1
		end
		if (i_wr && i_addr == ADDR_FMT) begin
			fmt_next = i_wdata[FMT_EXT_BIT];                   // RL4
		end
		if (i_wr && i_addr == ADDR_NSST) begin
			kind_next = i_wdata[KIND_LSB +: 8];
			ptpl_next = i_wdata[NSST_PTPL_BIT];
		end
		// Table holds only so many entries, so larger counts saturate
		if (i_wr && i_addr == ADDR_RCNT) begin
			rcnt_next = (i_wdata > 32'(COUNT_MAX)) ? COUNT_MAX : i_wdata[2:0];
		end
		if (i_rd) begin
			if (i_addr[ENT_SEL_BIT]) begin
				unique case (ent_fld)
					FLD_ID:     rdata_next = {15'h0000, hold_mem[ent_idx], id_mem[ent_idx]};
					FLD_HID_LO: rdata_next = hid_mem[ent_idx][31:0];
					FLD_HID_HI: rdata_next = hid_mem[ent_idx][63:32];
					FLD_KEY_LO: rdata_next = key_mem[ent_idx][31:0];
					FLD_KEY_HI: rdata_next = key_mem[ent_idx][63:32];
					default:    rdata_next = 32'h00000000;
				endcase
			end else begin
				unique case (i_addr)
					ADDR_WCNT: rdata_next = wcnt_reg;
					ADDR_FMT:  rdata_next = 32'(fmt_reg);
					ADDR_NSST: rdata_next = {23'h000000, ptpl_reg, kind_reg};
					ADDR_RCNT: rdata_next = 32'(rcnt_reg);
					ADDR_STAT: rdata_next = {30'h00000000, done_reg, state_reg != RRB_IDLE};
					ADDR_GEN:  rdata_next = gen;
					default:   rdata_next = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			wcnt_reg <= 32'h00000000;
			fmt_reg  <= 1'b0;
			kind_reg <= 8'h00;
			ptpl_reg <= 1'b0;
			rcnt_reg <= 3'h0;
			o_rdata  <= 32'h00000000;
		end else begin
			wcnt_reg <= wcnt_next;
			fmt_reg  <= fmt_next;
			kind_reg <= kind_next;
			ptpl_reg <= ptpl_next;
			rcnt_reg <= rcnt_next;
			o_rdata  <= rdata_next;
		end
	end

	// Registrant table; entries may change mid-report, header fields do not
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < ENTRY_MAX; i++) begin
				id_mem[i]   <= 16'h0000;
				hold_mem[i] <= 1'b0;
				hid_mem[i]  <= 64'h0000000000000000;
				key_mem[i]  <= 64'h0000000000000000;
			end
		end else if (ent_wr) begin
			unique case (ent_fld)
				FLD_ID: begin
					id_mem[ent_idx]   <= i_wdata[15:0];
					hold_mem[ent_idx] <= i_wdata[HOLD_BIT];
				end
				FLD_HID_LO: hid_mem[ent_idx][31:0]  <= i_wdata;
				FLD_HID_HI: hid_mem[ent_idx][63:32] <= i_wdata;
				FLD_KEY_LO: key_mem[ent_idx][31:0]  <= i_wdata;
				FLD_KEY_HI: key_mem[ent_idx][63:32] <= i_wdata;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Report sequencer: one dword per cycle, then a completion
	always_comb begin
		state_next     = state_reg;
		done_next      = done_reg;
		ext_next       = ext_reg;
		cnt_snap_next  = cnt_snap_reg;
		kind_snap_next = kind_snap_reg;
		ptpl_snap_next = ptpl_snap_reg;
		gen_snap_next  = gen_snap_reg;
		words_next     = words_reg;
		sent_next      = sent_reg;
		ofs_next       = ofs_reg;
		ent_next       = ent_reg;
		in_hdr_next    = in_hdr_reg;
		dv_next        = 1'b0;
		dw_next        = 32'h00000000;
		cqe_next       = 1'b0;
		rec_last       = (in_hdr_reg ? (ext_reg ? EXT_HDR_WORDS : STD_HDR_WORDS)
			: (ext_reg ? EXT_ENT_WORDS : STD_ENT_WORDS)) - 5'h01;
		unique case (state_reg)
			RRB_IDLE: begin
				// Starts while busy are ignored; snapshot keeps header coherent
				if (start) begin
					state_next     = RRB_SEND;
					done_next      = 1'b0;
					ext_next       = fmt_reg;                      // RL4
					cnt_snap_next  = rcnt_reg;
					kind_snap_next = kind_reg;
					ptpl_snap_next = ptpl_reg;
					gen_snap_next  = gen;
					words_next     = clamp_words;                  // RL2 RL3
					sent_next      = 32'h00000000;
					ofs_next       = 5'h00;
					ent_next       = 3'h0;
					in_hdr_next    = 1'b1;
				end
			end
			RRB_SEND: begin
				dv_next = 1'b1;
				if (in_hdr_reg) begin
					unique case (ofs_reg)
						HDR_W_GEN: dw_next = gen_snap_reg;            // RL5
						HDR_W_KIND: begin
							dw_next[KIND_LSB +: 8]   = kind_snap_reg;      // RL9
							dw_next[COUNT_LSB +: 16] = 16'(cnt_snap_reg);  // RL10
						end
						HDR_W_PTPL: dw_next[PTPL_BIT] = ptpl_snap_reg;  // RL11
						default: dw_next = 32'h00000000;                // RL13
					endcase
				end else if (ofs_reg == ENT_W_ID) begin
					dw_next[15:0]     = id_mem[cur_ent];                // RL14
					dw_next[HOLD_BIT] = hold_mem[cur_ent];
				end else if (ofs_reg == (ext_reg ? EXT_W_KEY : STD_W_KEY)) begin
					dw_next = key_mem[cur_ent][31:0];
				end else if (ofs_reg == (ext_reg ? EXT_W_KEY : STD_W_KEY) + 5'h01) begin
					dw_next = key_mem[cur_ent][63:32];
				end else if (ofs_reg == (ext_reg ? EXT_W_HID : STD_W_HID)) begin
					dw_next = hid_mem[cur_ent][31:0];
				end else if (ofs_reg == (ext_reg ? EXT_W_HID : STD_W_HID) + 5'h01) begin
					dw_next = hid_mem[cur_ent][63:32];
				end
				// Walk header then records of the chosen stride
				if (ofs_reg == rec_last) begin
					ofs_next    = 5'h00;                              // RL12 RL13
					in_hdr_next = 1'b0;
					if (!in_hdr_reg) begin
						ent_next = ent_reg + 3'h1;
					end
				end else begin
					ofs_next = ofs_reg + 5'h01;
				end
				sent_next = sent_reg + 32'h00000001;
				if (sent_reg == words_reg - 32'h00000001) begin
					state_next = RRB_CPL;                              // RL2 RL3
				end
			end
			RRB_CPL: begin
				cqe_next   = 1'b1;                                 // RL15
				done_next  = 1'b1;
				state_next = RRB_IDLE;
			end
			default: state_next = RRB_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg     <= RRB_IDLE;
			done_reg      <= 1'b0;
			ext_reg       <= 1'b0;
			cnt_snap_reg  <= 3'h0;
			kind_snap_reg <= 8'h00;
			ptpl_snap_reg <= 1'b0;
			gen_snap_reg  <= 32'h00000000;
			words_reg     <= 32'h00000000;
			sent_reg      <= 32'h00000000;
			ofs_reg       <= 5'h00;
			ent_reg       <= 3'h0;
			in_hdr_reg    <= 1'b1;
			o_data_valid  <= 1'b0;
			o_data_word   <= 32'h00000000;
			o_cqe_valid   <= 1'b0;
			o_cqe_status  <= STATUS_SUCCESS;
			o_busy        <= 1'b0;
		end else begin
			state_reg     <= state_next;
			done_reg      <= done_next;
			ext_reg       <= ext_next;
			cnt_snap_reg  <= cnt_snap_next;
			kind_snap_reg <= kind_snap_next;
			ptpl_snap_reg <= ptpl_snap_next;
			gen_snap_reg  <= gen_snap_next;
			words_reg     <= words_next;
			sent_reg      <= sent_next;
			ofs_reg       <= ofs_next;
			ent_reg       <= ent_next;
			in_hdr_reg    <= in_hdr_next;
			o_data_valid  <= dv_next;
			o_data_word   <= dw_next;
			o_cqe_valid   <= cqe_next;
			o_cqe_status  <= STATUS_SUCCESS;
			o_busy        <= state_next != RRB_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks, with a beat counter as helper
	logic [31:0] beat_reg;
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			beat_reg <= 32'h00000000;
		end else if (state_reg == RRB_IDLE && start) begin
			beat_reg <= 32'h00000000;
		end else if (o_data_valid) begin
			beat_reg <= beat_reg + 32'h00000001;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	sequence s_last_beat;
		state_reg == RRB_SEND && sent_reg == words_reg - 32'h00000001;
	endsequence
	sequence s_cpl_pulse;
		o_data_valid && !o_cqe_valid ##1 o_cqe_valid && !o_data_valid ##1 !o_cqe_valid;
	endsequence

	property p_cpl_after_last;
		s_last_beat |=> s_cpl_pulse;
	endproperty
	a_cpl_after_last: assert property (p_cpl_after_last) else $error("completion not after last word"); // RL15

	property p_exact_words;
		o_cqe_valid |-> beat_reg == words_reg;
	endproperty
	a_exact_words: assert property (p_exact_words) else $error("word count differs from request"); // RL2

	property p_no_overrun;
		// Subtract from words, which is at least one here, so an all-ones request cannot wrap
		o_data_valid |-> beat_reg < words_reg && words_reg - 32'h00000001 <= wcnt_reg;
	endproperty
	a_no_overrun: assert property (p_no_overrun) else $error("words beyond structure or request"); // RL3

	property p_gen_first;
		$rose(o_data_valid) |-> o_data_word == gen_snap_reg;
	endproperty
	a_gen_first: assert property (p_gen_first) else $error("first word is not the generation"); // RL5

	property p_kind_word;
		state_reg == RRB_SEND && in_hdr_reg && ofs_reg == HDR_W_KIND |=>
			o_data_word[KIND_LSB +: 8] == kind_snap_reg;
	endproperty
	a_kind_word: assert property (p_kind_word) else $error("reservation kind misplaced"); // RL9

	property p_count_word;
		state_reg == RRB_SEND && in_hdr_reg && ofs_reg == HDR_W_KIND |=>
			o_data_word[COUNT_LSB +: 16] == 16'(cnt_snap_reg);
	endproperty
	a_count_word: assert property (p_count_word) else $error("registrant count misplaced"); // RL10

	property p_ptpl_word;
		state_reg == RRB_SEND && in_hdr_reg && ofs_reg == HDR_W_PTPL |=>
			o_data_word == 32'(ptpl_snap_reg) << PTPL_BIT;
	endproperty
	a_ptpl_word: assert property (p_ptpl_word) else $error("persistence word wrong"); // RL11

	property p_hdr_len;
		state_reg == RRB_SEND && in_hdr_reg ##1 state_reg == RRB_SEND && !in_hdr_reg |->
			$past(ofs_reg) == (ext_reg ? EXT_HDR_WORDS : STD_HDR_WORDS) - 5'h01;
	endproperty
	a_hdr_len: assert property (p_hdr_len) else $error("header length wrong for format"); // RL4

	property p_entry_id;
		state_reg == RRB_SEND && !in_hdr_reg && ofs_reg == ENT_W_ID && !ent_wr |=>
			o_data_word[15:0] == id_mem[$past(cur_ent)];
	endproperty
	a_entry_id: assert property (p_entry_id) else $error("entry does not open with its id"); // RL14
endmodule

// ==== tb/rrb_host_model.sv ====
`timescale 1ns/10ps
module rrb_host_model (
	input  wire logic        i_clock,      // Core clock
	input  wire logic        i_nrst,       // Async reset, active low
	input  wire logic        i_data_valid, // Report word strobe
	input  wire logic [31:0] i_data_word,  // Report word
	input  wire logic        i_cqe_valid,  // Completion pulse
	input  wire logic [15:0] i_cqe_status  // Completion status
);
	logic [31:0] words[$];
	int          n_cqe;
	logic [15:0] last_status;
	// Host memory keeps every dword written, so a stray extra word shows in the count
	always @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			n_cqe = 0;
		end else begin
			if (i_data_valid === 1'b1) words.push_back(i_data_word);
			if (i_cqe_valid === 1'b1) begin
				n_cqe++;
				last_status = i_cqe_status;
			end
		end
	end
endmodule

// ==== tb/reservation_report_builder_tb.sv ====
`timescale 1ns/10ps
module reservation_report_builder_tb import rrb_pkg::*;;
	logic        i_clock, i_nrst, i_wr, i_rd, i_register_ok, i_release_ok, i_acquire_ok;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, o_data_word, gen_model, v;
	logic [2:0]  i_release_action_code, i_acquire_action_code, cnt;
	logic        o_data_valid, o_cqe_valid, o_busy, ptpl;
	logic [15:0] o_cqe_status, ent_id[4];
	logic [7:0]  kind;
	logic        ent_hold[4];
	logic [63:0] hid[4], key[4];
	int          n_errors, compares;
	////////////////////////////////////////////////////////////////////////////////
	rrb_report_builder DUT (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_register_ok(i_register_ok),
		.i_release_ok(i_release_ok), .i_release_action_code(i_release_action_code),
		.i_acquire_ok(i_acquire_ok), .i_acquire_action_code(i_acquire_action_code),
		.o_data_valid(o_data_valid), .o_data_word(o_data_word), .o_cqe_valid(o_cqe_valid),
		.o_cqe_status(o_cqe_status), .o_busy(o_busy));
	rrb_host_model host (.i_clock(i_clock), .i_nrst(i_nrst), .i_data_valid(o_data_valid),
		.i_data_word(o_data_word), .i_cqe_valid(o_cqe_valid), .i_cqe_status(o_cqe_status));
	// 125 MHz core clock
	always #4 i_clock = ~i_clock;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Bus cycles: strobe held one cycle, read data taken just after the answering edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask
	// Entries are as long as the header in both formats, which keeps the index math shared
	function automatic logic [31:0] exp_word(input logic ext, input logic [31:0] snap, input int idx);
		int hw;
		int n;
		hw = ext ? 16 : 6;
		if (idx < hw) begin
			case (idx)
				0: return snap;
				1: return {16'h0000, 5'h00, cnt, kind};
				2: return {23'h000000, ptpl, 8'h00};
				default: return 32'h00000000;
			endcase
		end
		n = (idx - hw) / hw;
		case ((idx - hw) % hw)
			0: return {15'h0000, ent_hold[n], ent_id[n]};
			2: return ext ? key[n][31:0] : hid[n][31:0];
			3: return ext ? key[n][63:32] : hid[n][63:32];
			4: return ext ? hid[n][31:0] : key[n][31:0];
			5: return ext ? hid[n][63:32] : key[n][63:32];
			default: return 32'h00000000;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Random success pulses with every action code; only qualifying ones advance
	task automatic gen_pulses();
		logic [31:0] r;
		for (int i = 0; i < 60; i++) begin
			@(posedge i_clock);
			r = $urandom();
			i_register_ok <= r[0];
			i_release_ok <= r[1];
			i_release_action_code <= r[4:2];
			i_acquire_ok <= r[5];
			i_acquire_action_code <= r[8:6];
			gen_model = gen_model + r[0] + (r[1] && r[4:2] == REL_CLEAR)
				+ (r[5] && (r[8:6] == ACQ_PREEMPT || r[8:6] == ACQ_PREEMPT_ABORT));
		end
		@(posedge i_clock);
		{i_register_ok, i_release_ok, i_acquire_ok} <= 3'h0;
		rd(ADDR_GEN, v);
		check("generation", v, gen_model);
	endtask
	task automatic run_report(input logic ext, input logic [31:0] wcnt);
		logic [31:0] snap;
		int size;
		int n;
		int n0;
		size = (ext ? 16 : 6) * (cnt + 1);
		n = (wcnt >= size) ? size : wcnt + 1;
		wr(ADDR_WCNT, wcnt);
		wr(ADDR_FMT, {31'h00000000, ext});
		host.words.delete();
		n0 = host.n_cqe;
		snap = gen_model;
		wr(ADDR_CTRL, 32'h00000001);
		#1;
		check("busy", {31'h00000000, o_busy}, 32'h00000001);
		// A bump during the report must not reach the snapshot header
		@(posedge i_clock);
		i_register_ok <= 1'b1;
		@(posedge i_clock);
		i_register_ok <= 1'b0;
		gen_model++;
		if (n > 4) wr(ADDR_CTRL, 32'h00000001);
		for (int w = 0; w < 300 && host.n_cqe == n0; w++) @(posedge i_clock);
		repeat (4) @(posedge i_clock);
		check("cqe count", host.n_cqe - n0, 32'h00000001);
		check("cqe status", {16'h0000, host.last_status}, {16'h0000, STATUS_SUCCESS});
		check("word count", host.words.size(), n);
		for (int i = 0; i < n && i < host.words.size(); i++) check("report word", host.words[i], exp_word(ext, snap, i));
		rd(ADDR_STAT, v);
		check("status", v, 32'h00000002);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: table of formats, counts and lengths around the structure size
	initial begin
		logic [31:0] r;
		logic [31:0] wcnt;
		int size;
		{i_clock, i_nrst, i_wr, i_rd, i_register_ok, i_release_ok, i_acquire_ok} = 7'h00;
		{i_addr, i_wdata, i_release_action_code, i_acquire_action_code} = 46'h0;
		{n_errors, compares, gen_model} = 96'h0;
		r = $urandom(32'h261E);
		repeat (6) @(posedge i_clock);
		i_nrst <= 1'b1;
		rd(ADDR_GEN, v);
		check("generation reset", v, 32'h00000000);
		rd(8'h40, v);
		check("unmapped read", v, 32'h00000000);
		for (int t = 0; t < 12; t++) begin
			gen_pulses();
			r = $urandom();
			kind = r[7:0];
			ptpl = r[8];
			cnt = (t == 0) ? 3'h0 : (t == 1 ? 3'h4 : 3'(r % 5));
			wr(ADDR_NSST, {23'h000000, ptpl, kind});
			wr(ADDR_RCNT, (t == 1) ? 32'h00000007 : {29'h00000000, cnt});
			for (int n = 0; n < 4; n++) begin
				r = $urandom();
				ent_id[n] = r[15:0];
				ent_hold[n] = r[16];
				hid[n] = {$urandom(), $urandom()};
				key[n] = {$urandom(), $urandom()};
				wr({1'b1, 2'(n), 5'h00}, {15'h0000, ent_hold[n], ent_id[n]});
				wr({1'b1, 2'(n), 5'h04}, hid[n][31:0]);
				wr({1'b1, 2'(n), 5'h08}, hid[n][63:32]);
				wr({1'b1, 2'(n), 5'h0C}, key[n][31:0]);
				wr({1'b1, 2'(n), 5'h10}, key[n][63:32]);
			end
			size = ((t % 2) ? 16 : 6) * (cnt + 1);
			case (t / 2)
				0: wcnt = 32'h00000000;
				1: wcnt = size - 2;
				2: wcnt = size - 1;
				3: wcnt = size;
				4: wcnt = 32'hFFFFFFFF;
				default: wcnt = $urandom_range(90, 0);
			endcase
			run_report(1'(t % 2), wcnt);
		end
		complete_run();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#(40000 * 8);
		n_errors++;
		complete_run();
	end
endmodule
